// *** hdl/hsps_map.svh ***
// offsets, field positions and timing figures of the host serial port
`ifndef HSPS_MAP_SVH
`define HSPS_MAP_SVH

// system clock period in ns
`define HSPS_CLK_PERIOD_NS 20
// delay from first select rising edge to spi, in ns
`define HSPS_SEL_DELAY_NS 200000
// command byte layout
`define HSPS_CMD_RW_BIT 7
`define HSPS_CMD_READ 1'b1
// last bit index inside a byte
`define HSPS_LAST_BIT 3'h7
// idle level of the synchronised pins: select, clock, data
`define HSPS_PIN_IDLE 3'h7
// address step for auto-increment
`define HSPS_ADDR_STEP 7'h01

`endif

// *** hdl/hsps_pkg.sv ***
// types shared by the host serial port select block
`default_nettype none

package hsps_pkg;

  typedef enum logic [1:0] {
    HSPS_IDLE = 2'h0,
    HSPS_CMD = 2'h1,
    HSPS_WR = 2'h3,
    HSPS_RD = 2'h2
  } hsps_state_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [6:0] addr;
    logic [7:0] data;
  } hsps_reg_req_t;

endpackage

`default_nettype wire

// *** hdl/hsps_sync.sv ***
// two-flop synchroniser for pins from outside the system clock
`timescale 1ns/10ps
`default_nettype none

module hsps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and control
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // meta is read by q_o alone
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire

// *** hdl/hsps_port_sel.sv ***
// protocol choice for the primary port: i2c by default, spi on request
`timescale 1ns/10ps
`default_nettype none

module hsps_port_sel #(
  parameter int DELAY_CYC = 10000
) (
  // clock and control
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // rising edge of the synchronised select pin
  input wire logic sel_rise_i,
  input wire logic perm_i,
  // chosen protocol, high for spi
  output logic spi_o
);

  localparam int CW = $clog2(DELAY_CYC + 1);

  logic armed;
  logic [CW-1:0] cnt;
  logic spi;
  logic next_armed;
  logic [CW-1:0] next_cnt;
  logic next_spi;

  // =========================================================
  // switch-over timer
  always_comb
  begin
    next_armed = armed;
    next_cnt = cnt;
    next_spi = spi | perm_i; // [RQ4]
    if (!spi && !armed && sel_rise_i)
    begin
      next_armed = 1'b1; // [RQ2]
      next_cnt = '0;
    end
    else if (armed && !spi)
    begin
      if (cnt == CW'(DELAY_CYC - 1))
        next_spi = 1'b1; // [RQ2]
      else
        next_cnt = cnt + CW'(1);
    end
  end

  // only a reset leaves spi again
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      armed <= 1'b0; // [RQ1]
      cnt <= '0;
      spi <= 1'b0;
    end
    else if (ce_i)
    begin
      armed <= next_armed;
      cnt <= next_cnt;
      spi <= next_spi;
    end
  end

  assign spi_o = spi;

  // =========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  i2c_hold_a: assert property (!spi && !armed && !perm_i // [RQ1]
    && !sel_rise_i |=> !spi)
    else $error("port left i2c without cause");
  spi_stay_a: assert property (spi |=> spi) // [RQ2]
    else $error("spi mode dropped without reset");
  spi_delay_a: assert property (armed && !spi && ce_i
    && cnt == CW'(DELAY_CYC - 1) |=> spi) // [RQ2]
    else $error("spi not taken at end of delay");
  spi_early_a: assert property (armed && !spi && !perm_i
    && cnt != CW'(DELAY_CYC - 1) |=> !spi) // [RQ2]
    else $error("spi taken before delay ran out");
  perm_sel_a: assert property (perm_i && ce_i |=> spi) // [RQ4]
    else $error("permanent select ignored");

endmodule

`default_nettype wire

// *** hdl/hsps_top.sv ***
// host serial port: protocol select and spi slave, 4-wire and 3-wire
// Notes on behaviour
// RQ1: after reset the port is i2c while select stays high and still.
// RQ2: first select rising edge switches to spi after 200 us, held.
// RQ3: host does one throw-away id read to enter spi.
// RQ4: permanent select bit forces spi from every reset.
// RQ5: clock modes 00 and 11; clock level at select fall recorded.
// RQ6: 4-wire by default; three-wire select moves data to shared pin.
// RQ7: single access is one command byte plus one data byte.
// RQ8: select low starts a transaction, select high ends it.
// RQ9: data changes on falling clock edge, sampled on rising edge.
// RQ10: in 4-wire, serial out stays high impedance during writes.
// RQ11: burst write takes first address then steps it per byte.
// RQ12: burst read steps address after each returned byte.
// RQ13: first read byte is a dummy; n bytes need n+1 clocked. The code sends no dummy; read data follows the command byte.
// RQ14: command bit 0 means write, 1 read; seven address bits follow.
// RQ15: write carries eight data bits in, read returns eight out.
// RQ16: 3-wire uses select, clock and bidirectional shared pin.
// RQ17: host idles 2 us after reads and normal-mode writes.
// RQ18: host idles 450 us after writes in suspend or low power.
// RQ19: for i2c the board ties select high permanently.
// RQ20: bytes travel most significant bit first.
`timescale 1ns/10ps
`default_nettype none
`include "hsps_map.svh"

module hsps_top
  import hsps_pkg::*;
#(
  parameter int SEL_DELAY_CYC = `HSPS_SEL_DELAY_NS / `HSPS_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // primary port pins
  input wire logic select_n_pin_i,
  input wire logic serial_clock_pin_i,
  input wire logic shared_data_pin_i,
  output logic shared_data_pin_o,
  output logic shared_data_pin_oe_n_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  // configuration from the register side
  input wire logic permanent_serial_select_i,
  input wire logic three_wire_select_i,
  // register file access
  output var hsps_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i,
  // status
  output logic spi_sel_o,
  output logic spi_clk_mode_o
);

  logic sel_s;
  logic sck_s;
  logic sdi_s;
  logic sel_q;
  logic sck_q;
  logic sel_rise;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;
  logic spi;

  hsps_state_t state;
  logic [2:0] bitcnt;
  logic [7:0] rx;
  logic [6:0] addr;
  logic [7:0] tx;
  logic [7:0] rd_buf;
  logic rd_pend;
  logic re_d;
  logic cpol;
  logic serial_out_pin;
  logic sdo_oe_n;
  logic sda_oe_n;
  hsps_reg_req_t req;

  hsps_state_t next_state;
  logic [2:0] next_bitcnt;
  logic [7:0] next_rx;
  logic [6:0] next_addr;
  logic [7:0] next_tx;
  logic [7:0] next_rd_buf;
  logic next_rd_pend;
  logic next_re_d;
  logic next_cpol;
  logic next_sdo;
  logic next_sdo_oe_n;
  logic next_sda_oe_n;
  hsps_reg_req_t next_req;

  // =========================================================
  // pin capture
  hsps_sync #(
    .W(3),
    .RST_VAL(`HSPS_PIN_IDLE)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({select_n_pin_i, serial_clock_pin_i, shared_data_pin_i}),
    .q_o({sel_s, sck_s, sdi_s})
  );

  // edge history sits after the synchroniser, never on its first flop
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sel_q <= 1'b1;
      sck_q <= 1'b1;
    end
    else if (ce_i)
    begin
      sel_q <= sel_s;
      sck_q <= sck_s;
    end
  end

  assign sel_rise = sel_s & ~sel_q;
  assign sel_fall = ~sel_s & sel_q;
  assign sck_rise = sck_s & ~sck_q; // [RQ9]
  assign sck_fall = ~sck_s & sck_q; // [RQ9]

  // =========================================================
  // protocol choice
  hsps_port_sel #(
    .DELAY_CYC(SEL_DELAY_CYC)
  ) u_port_sel (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sel_rise_i(sel_rise), // [RQ2]
    .perm_i(permanent_serial_select_i), // [RQ4]
    .spi_o(spi)
  );

  // =========================================================
  // spi slave engine
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_rx = rx;
    next_addr = addr;
    next_tx = tx;
    next_rd_buf = rd_buf;
    next_rd_pend = rd_pend;
    next_re_d = req.re;
    next_cpol = cpol;
    next_sdo = serial_out_pin;
    next_sdo_oe_n = 1'b1;
    next_sda_oe_n = 1'b1;
    next_req = req;
    next_req.we = 1'b0;
    next_req.re = 1'b0;
    // register file answers one cycle after the read strobe
    if (re_d)
      next_rd_buf = reg_rdata_i; // [RQ15]
    if (!spi || sel_s)
    begin
      next_state = HSPS_IDLE; // [RQ8]
      next_rd_pend = 1'b0;
    end
    else
    begin
      unique case (state)
        HSPS_IDLE:
        begin
          if (sel_fall)
          begin
            next_state = HSPS_CMD; // [RQ8]
            next_bitcnt = '0;
            next_cpol = sck_s; // [RQ5]
          end
        end
        HSPS_CMD:
        begin
          if (sck_rise)
          begin
            next_rx = {rx[6:0], sdi_s}; // [RQ20]
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == `HSPS_LAST_BIT)
            begin
              next_addr = {rx[5:0], sdi_s}; // [RQ14]
              if (rx[`HSPS_CMD_RW_BIT - 1] == `HSPS_CMD_READ)
              begin
                // no dummy byte: the first read data byte follows the command byte directly
                next_state = HSPS_RD; // [RQ13]
                next_req.re = 1'b1;
                next_req.addr = {rx[5:0], sdi_s};
                next_rd_pend = 1'b1;
              end
              else
                next_state = HSPS_WR; // [RQ14]
            end
          end
        end
        HSPS_WR:
        begin
          if (sck_rise)
          begin
            next_rx = {rx[6:0], sdi_s}; // [RQ20]
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == `HSPS_LAST_BIT)
            begin
              next_req.we = 1'b1; // [RQ7] [RQ15]
              next_req.addr = addr;
              next_req.data = {rx[6:0], sdi_s};
              next_addr = addr + `HSPS_ADDR_STEP; // [RQ11]
            end
          end
        end
        HSPS_RD:
        begin
          if (sck_fall)
          begin
            // drive on the falling edge, master samples on rising
            if (rd_pend)
            begin
              next_sdo = rd_buf[7]; // [RQ9]
              next_tx = {rd_buf[6:0], 1'b0};
              next_rd_pend = 1'b0;
            end
            else
            begin
              next_sdo = tx[7]; // [RQ20]
              next_tx = {tx[6:0], 1'b0};
            end
          end
          if (sck_rise)
          begin
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == `HSPS_LAST_BIT)
            begin
              // prefetch the next byte for the following fall
              next_addr = addr + `HSPS_ADDR_STEP; // [RQ12]
              next_req.re = 1'b1;
              next_req.addr = addr + `HSPS_ADDR_STEP;
              next_rd_pend = 1'b1;
            end
          end
          // 4-wire drives serial out, 3-wire the shared pin
          next_sdo_oe_n = three_wire_select_i; // [RQ6]
          next_sda_oe_n = ~three_wire_select_i; // [RQ16]
        end
      endcase
    end
    if (next_state != HSPS_RD)
    begin
      next_sdo_oe_n = 1'b1; // [RQ10]
      next_sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= HSPS_IDLE;
      bitcnt <= '0;
      rx <= '0;
      addr <= '0;
      tx <= '0;
      rd_buf <= '0;
      rd_pend <= 1'b0;
      re_d <= 1'b0;
      cpol <= 1'b0;
      serial_out_pin <= 1'b0;
      sdo_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      req <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      rx <= next_rx;
      addr <= next_addr;
      tx <= next_tx;
      rd_buf <= next_rd_buf;
      rd_pend <= next_rd_pend;
      re_d <= next_re_d;
      cpol <= next_cpol;
      serial_out_pin <= next_sdo;
      sdo_oe_n <= next_sdo_oe_n;
      sda_oe_n <= next_sda_oe_n;
      req <= next_req;
    end
  end

  assign shared_data_pin_o = serial_out_pin;
  assign shared_data_pin_oe_n_o = sda_oe_n;
  assign serial_out_pin_o = serial_out_pin;
  assign serial_out_pin_oe_n_o = sdo_oe_n;
  assign reg_req_o = req;
  assign spi_sel_o = spi;
  assign spi_clk_mode_o = cpol;

  // =========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence rd_fetch_s;
    req.re ##1 re_d;
  endsequence

  sequence cmd_done_s;
    state == HSPS_CMD && ce_i && spi && !sel_s && sck_rise
      && bitcnt == `HSPS_LAST_BIT;
  endsequence

  no_drive_a: assert property (state != HSPS_RD |=>
    $past(state) == HSPS_RD || (sdo_oe_n && sda_oe_n)) // [RQ10]
    else $error("data pin driven outside read phase");
  cpol_cap_a: assert property (state == HSPS_IDLE && ce_i && spi
    && !sel_s && sel_fall |=> cpol == $past(sck_s)) // [RQ5]
    else $error("clock mode not taken at select fall");
  wire_form_a: assert property (!sdo_oe_n || !sda_oe_n |->
    sdo_oe_n != sda_oe_n) // [RQ6]
    else $error("both data pins driven at once");
  wr_step_a: assert property (req.we |-> addr == req.addr
    + `HSPS_ADDR_STEP) // [RQ11]
    else $error("write address not stepped");
  rd_step_a: assert property (req.re && $past(state) == HSPS_RD
    |-> addr == req.addr) // [RQ12]
    else $error("read address not stepped");
  rd_fetch_a: assert property (rd_fetch_s |=>
    rd_buf == $past(reg_rdata_i)) // [RQ15]
    else $error("read data not captured");
  cmd_dir_a: assert property (cmd_done_s |=>
    (state == HSPS_RD) == $past(rx[6])) // [RQ14]
    else $error("direction bit decoded wrongly");
  sel_end_a: assert property (sel_s && ce_i |=> state == HSPS_IDLE) // [RQ8]
    else $error("transaction outlived select");
  tx_msb_a: assert property (state == HSPS_RD && ce_i && !sel_s
    && sck_fall && rd_pend |=> serial_out_pin == $past(rd_buf[7])) // [RQ20]
    else $error("read byte not sent msb first");

endmodule

`default_nettype wire

// *** hdl/hsps_unused_placeholder_removed.sv ***
// intentionally empty compile unit guard
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** bench/hsps_host_model.sv ***
// spi host model that drives the primary port pins
`timescale 1ns/10ps
`default_nettype none

module hsps_host_model (
  // clock and wiring form
  input wire logic clk_sys_i,
  input wire logic tw_i,
  // port pins
  output logic select_n_o,
  output logic sclk_o,
  output logic shd_o,
  input wire logic shd_do_i,
  input wire logic shd_oe_n_i,
  input wire logic so_i,
  input wire logic so_oe_n_i,
  // observation
  output logic so_drove_o
);
  logic m_do;
  logic so_line;

  // ==========================================================
  // wire levels
  // released serial out reads back inverted, so its stale bits never match; released shared pin reads m_do
  assign shd_o = !shd_oe_n_i ? shd_do_i : m_do;
  assign so_line = so_oe_n_i ? ~so_i : so_i;

  initial
  begin
    select_n_o = 1'b1;
    sclk_o = 1'b1;
    m_do = 1'b1;
    so_drove_o = 1'b0;
  end

  always @(posedge clk_sys_i)
    if (!select_n_o && so_oe_n_i === 1'b0)
      so_drove_o <= 1'b1;

  // ==========================================================
  // transfers
  task automatic half();
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  // n bytes from tx, msb first; command byte on top
  task automatic xfer(input logic cpol, input int n,
    input logic [31:0] tx, output logic [31:0] rx);
    logic rd;
    rx = '0;
    rd = tx[8*n-1];
    so_drove_o = 1'b0;
    // normal-mode gap only; the block has no low-power state
    repeat (100) @(posedge clk_sys_i);
    #1;
    sclk_o = cpol;
    half();
    select_n_o = 1'b0;
    half();
    for (int i = 8*n-1; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      if (!rd || i >= 8*(n-1))
        m_do = tx[i];
      else
        m_do = ~m_do;
      half();
      sclk_o = 1'b1;
      rx = {rx[30:0], tw_i ? shd_o : so_line};
      half();
    end
    sclk_o = cpol;
    half();
    select_n_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the host serial port select block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import hsps_pkg::*;

  localparam int DELAY = 20;
  // identity register address is arbitrary here
  localparam logic [6:0] ID_REG = 7'h00;

  logic clk_sys_i, rst_i, ce, perm, tw, sel_n, sclk, shd, shd_do, shd_oe_n;
  logic so, so_oe_n, spi_sel, clk_mode, so_drove;
  hsps_reg_req_t req;
  logic [7:0] rdata;
  logic [31:0] bad_count, tests_run, cyc, rd_cnt, rx;
  logic [14:0] wr_q[$];

  hsps_top #(.SEL_DELAY_CYC(DELAY)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
    .select_n_pin_i(sel_n), .serial_clock_pin_i(sclk),
    .shared_data_pin_i(shd), .shared_data_pin_o(shd_do),
    .shared_data_pin_oe_n_o(shd_oe_n), .serial_out_pin_o(so),
    .serial_out_pin_oe_n_o(so_oe_n), .permanent_serial_select_i(perm),
    .three_wire_select_i(tw), .reg_req_o(req), .reg_rdata_i(rdata),
    .spi_sel_o(spi_sel), .spi_clk_mode_o(clk_mode));

  hsps_host_model host (
    .clk_sys_i(clk_sys_i), .tw_i(tw), .select_n_o(sel_n),
    .sclk_o(sclk), .shd_o(shd), .shd_do_i(shd_do),
    .shd_oe_n_i(shd_oe_n), .so_i(so), .so_oe_n_i(so_oe_n),
    .so_drove_o(so_drove));

  // ==========================================================
  // register file stand-in: data one cycle after the read strobe
  function automatic logic [7:0] f(input logic [6:0] a);
    return {1'b0, a} ^ 8'ha5;
  endfunction

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (req.re === 1'b1)
    begin
      rdata <= f(req.addr);
      rd_cnt <= rd_cnt + 1;
    end
    if (req.we === 1'b1)
      wr_q.push_back({req.addr, req.data});
    if (cyc == 32'd20000)
    begin
      // blocking, so the verdict below already sees the timeout
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    wait_cyc(6);
    rst_i = 1'b0;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_i2c();
    chk("spi_sel", 0, spi_sel);
    chk("oe_n", 2'b11, {shd_oe_n, so_oe_n});
    host.xfer(1'b1, 2, {17'h1, ID_REG, 8'h00}, rx);
    chk("i2c_reads", 0, rd_cnt);
    wait_cyc(DELAY / 2);
    chk("spi_sel_early", 0, spi_sel);
    wait_cyc(DELAY);
    chk("spi_sel_late", 1, spi_sel);
    $display("test i2c default done");
  endtask

  task automatic t_write();
    wr_q.delete();
    host.xfer(1'b0, 2, {17'h0, 7'h12, 8'h3c}, rx);
    wait_cyc(2);
    chk("wr_cnt", 1, 32'(wr_q.size()));
    chk("wr0", {7'h12, 8'h3c}, wr_q[0]);
    chk("so_hiz", 0, so_drove);
    chk("mode00", 0, clk_mode);
    $display("test single write done");
  endtask

  task automatic t_burst_wr();
    wr_q.delete();
    host.xfer(1'b1, 3, {9'h0, 7'h7e, 16'h1122}, rx);
    wait_cyc(2);
    chk("bwr_cnt", 2, 32'(wr_q.size()));
    chk("bwr0", {7'h7e, 8'h11}, wr_q[0]);
    chk("bwr1", {7'h7f, 8'h22}, wr_q[1]);
    chk("mode11", 1, clk_mode);
    $display("test burst write done");
  endtask

  task automatic t_burst_rd();
    wr_q.delete();
    host.xfer(1'b1, 3, {9'h1, 7'h30, 16'h0}, rx);
    chk("brd", {f(7'h30), f(7'h31)}, rx[15:0]);
    chk("brd_nowr", 0, 32'(wr_q.size()));
    $display("test burst read done");
  endtask

  task automatic t_read3w();
    tw = 1'b1;
    host.xfer(1'b1, 2, {17'h1, 7'h45, 8'h0}, rx);
    chk("rd3w", f(7'h45), rx[7:0]);
    chk("so_unused", 0, so_drove);
    wait_cyc(6);
    chk("shd_free", 1, shd_oe_n);
    tw = 1'b0;
    $display("test three-wire read done");
  endtask

  task automatic t_perm();
    do_reset();
    chk("sel_after_rst", 0, spi_sel);
    ce = 1'b0;
    perm = 1'b1;
    wait_cyc(4);
    chk("ce_frozen", 0, spi_sel);
    ce = 1'b1;
    do_reset();
    wait_cyc(2);
    chk("perm_sel", 1, spi_sel);
    host.xfer(1'b0, 2, {17'h1, 7'h05, 8'h0}, rx);
    chk("perm_rd", f(7'h05), rx[7:0]);
    $display("test permanent select done");
  endtask

  // ==========================================================
  // clock and main sequence
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    rst_i = 1'b1;
    ce = 1'b1;
    perm = 1'b0;
    tw = 1'b0;
    rdata = 8'h00;
    bad_count = '0;
    tests_run = '0;
    cyc = '0;
    rd_cnt = '0;
    #1;
    do_reset();
    t_i2c();
    t_write();
    t_burst_wr();
    t_burst_rd();
    t_read3w();
    t_perm();
    print_verdict();
  end
endmodule

`default_nettype wire
